// ---- hdl/rbss_pkg.sv ----
// Shared constants, register map and bundle types of the roller blind sun-shading stage.
// Assumes one 100 MHz system clock and neighbouring stages on that same clock.
package rbss_pkg;

  // ****************************************************************
  // Clock and time base
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam longint SECOND_NS = 1_000_000_000;
  localparam int TICKS_PER_SECOND = int'(SECOND_NS / CLK_PERIOD_NS);

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int ANGLE_W = 16;
  localparam int TIME_W = 17;
  localparam int SEC_W = 16;
  localparam int LEVEL_W = 8;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // ****************************************************************
  // Register map (angles in tenths of a degree, times in seconds)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] REG_AZ_START = 4'h0;
  localparam logic [ADDR_W-1:0] REG_AZ_END = 4'h1;
  localparam logic [ADDR_W-1:0] REG_ELEV_LIMIT = 4'h2;
  localparam logic [ADDR_W-1:0] REG_MORNING_LAG = 4'h3;
  localparam logic [ADDR_W-1:0] REG_EVENING_LEAD = 4'h4;
  localparam logic [ADDR_W-1:0] REG_SUN_PERSIST = 4'h5;
  localparam logic [ADDR_W-1:0] REG_SHADE_LIMIT = 4'h6;
  localparam logic [ADDR_W-1:0] REG_STATE = 4'h7;

  localparam logic [ANGLE_W-1:0] AZ_START_RST = 16'h03e8;
  localparam logic [ANGLE_W-1:0] AZ_END_RST = 16'h0a28;
  localparam logic [ANGLE_W-1:0] ELEV_LIMIT_RST = 16'h0384;
  localparam logic [SEC_W-1:0] MORNING_LAG_RST = 16'h0e10;
  localparam logic [SEC_W-1:0] EVENING_LEAD_RST = 16'h0e10;
  localparam logic [SEC_W-1:0] SUN_PERSIST_RST = 16'h003c;
  localparam logic [LEVEL_W-1:0] SHADE_LIMIT_RST = 8'hff;

  // Fields of the read-only state register
  localparam int STATE_MODE_LSB = 0;
  localparam int STATE_SUN_HELD_BIT = 2;
  localparam int STATE_ELIGIBLE_BIT = 3;
  localparam int STATE_SECTOR_BIT = 4;
  localparam int STATE_WINDOW_BIT = 5;

  // ****************************************************************
  // Status codes
  // ****************************************************************
  localparam logic [LEVEL_W-1:0] STATUS_SHADE = 8'h97;
  localparam logic [LEVEL_W-1:0] STATUS_ALERT = 8'h98;

  typedef enum logic [1:0] {
    RBSS_PASS = 2'b00,
    RBSS_SHADE = 2'b01,
    RBSS_ALERT = 2'b11
  } rbss_mode_t;

  typedef struct packed {
    logic [ANGLE_W-1:0] azimuth;
    logic signed [ANGLE_W-1:0] elevation;
    logic [TIME_W-1:0] timeOfDay;
    logic [TIME_W-1:0] sunrise;
    logic [TIME_W-1:0] sunset;
  } rbss_calendar_t;

  typedef struct packed {
    logic upRequest;
    logic downRequest;
    logic [LEVEL_W-1:0] upstreamStatus;
    logic [LEVEL_W-1:0] requestedLevel;
  } rbss_request_t;

  typedef struct packed {
    logic motorRaise;
    logic motorLower;
    logic [LEVEL_W-1:0] status;
    logic [LEVEL_W-1:0] targetLevel;
  } rbss_command_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wrData;
    logic wrStrobe;
    logic rdStrobe;
  } rbss_regbus_t;

  typedef struct packed {
    logic [ANGLE_W-1:0] azStart;
    logic [ANGLE_W-1:0] azEnd;
    logic signed [ANGLE_W-1:0] elevLimit;
    logic [SEC_W-1:0] morningLag;
    logic [SEC_W-1:0] eveningLead;
    logic [SEC_W-1:0] sunPersist;
    logic [LEVEL_W-1:0] shadeLimit;
  } rbss_config_t;

  typedef struct packed {
    rbss_mode_t mode;
    rbss_config_t cfg;
    rbss_command_t cmd;
    logic [DATA_W-1:0] rdData;
  } rbss_top_state_t;

endpackage : rbss_pkg

// ---- hdl/rbss_sync.sv ----
// Two-stage synchroniser for pin inputs of the sun-shading stage.
// Assumes inputs that may change at any time relative to sys_clk.
`timescale 1ns/1ns
`default_nettype none
module rbss_sync #(
  parameter int WIDTH = 2
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic [WIDTH-1:0] asyncIn,
  output var logic [WIDTH-1:0] syncOut
);

  if (WIDTH < 1) begin : g_chk
    $error("rbss_sync: WIDTH must be at least 1");
  end

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } rbss_sync_state_t;

  rbss_sync_state_t state_q;
  rbss_sync_state_t state_d;

  // ****************************************************************
  // Only the second stage is read downstream
  // ****************************************************************
  always_comb begin
    state_d.stage1 = asyncIn;
    state_d.stage2 = state_q.stage1;
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign syncOut = state_q.stage2;

endmodule : rbss_sync
`default_nettype wire

// ---- hdl/rbss_persist_timer.sv ----
// Counts whole seconds for which the sun level has stayed true.
// Assumes a synchronised sun level on sys_clk.
`timescale 1ns/1ns
`default_nettype none
module rbss_persist_timer #(
  parameter int TICK_CYCLES = 100_000_000,
  parameter int SEC_W = 16
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic sunLevel,
  output var logic [SEC_W-1:0] secCount
);

  localparam int TICK_W = $clog2(TICK_CYCLES);

  if (TICK_CYCLES < 2 || SEC_W < 1) begin : g_chk
    $error("rbss_persist_timer: TICK_CYCLES must be at least 2");
  end

  typedef struct packed {
    logic [TICK_W-1:0] tick;
    logic [SEC_W-1:0] secs;
  } rbss_timer_state_t;

  rbss_timer_state_t state_q;
  rbss_timer_state_t state_d;

  always_comb begin
    state_d = state_q;
    if (!sunLevel) begin
      state_d = '0;
    end else if (state_q.tick == TICK_W'(TICK_CYCLES - 1)) begin
      state_d.tick = '0;
      // Saturate so a long sunny spell never wraps back below the threshold
      if (state_q.secs != '1) begin
        state_d.secs = state_q.secs + SEC_W'(1);
      end
    end else begin
      state_d.tick = state_q.tick + TICK_W'(1);
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign secCount = state_q.secs;

  property p_restart;
    @(posedge sys_clk) disable iff (!nrst)
    !sunLevel |=> (secCount == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("persist count not cleared");

endmodule : rbss_persist_timer
`default_nettype wire

// ---- hdl/rbss_top.sv ----
// Sun-shading stage of a roller blind control chain: pass-through, shading cap, forced open.
// Assumes preceding and following stages and the calendar source run on sys_clk;
// sun sensor and alert come from pins and are synchronised here.
`timescale 1ns/1ns
`default_nettype none

module rbss_top
  import rbss_pkg::*;
#(
  parameter int TICK_CYCLES = TICKS_PER_SECOND
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire rbss_request_t request,
  input wire logic shadeEnable,
  input wire logic sunSensor,
  input wire logic alertIn,
  input wire rbss_calendar_t calendarBus,
  input wire rbss_regbus_t regBus,
  output var logic [DATA_W-1:0] rdData,
  output var rbss_command_t command
);

  if (TICK_CYCLES < 2) begin : g_chk
    $error("rbss_top: TICK_CYCLES must be at least 2");
  end

  // ****************************************************************
  // Pin synchronisation and sun persistence
  // ****************************************************************
  logic [1:0] pinSync;
  logic sunSync;
  logic alertSync;
  logic [SEC_W-1:0] secCount;

  rbss_sync #(
    .WIDTH(2)
  ) u_sync (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .asyncIn({alertIn, sunSensor}),
    .syncOut(pinSync)
  );

  assign sunSync = pinSync[0];
  assign alertSync = pinSync[1];

  rbss_persist_timer #(
    .TICK_CYCLES(TICK_CYCLES),
    .SEC_W(SEC_W)
  ) u_timer (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .sunLevel(sunSync),
    .secCount(secCount)
  );

  // ****************************************************************
  // State
  // ****************************************************************
  rbss_top_state_t state_q;
  rbss_top_state_t state_d;

  localparam rbss_config_t CFG_RST = '{
    azStart: AZ_START_RST,
    azEnd: AZ_END_RST,
    elevLimit: ELEV_LIMIT_RST,
    morningLag: MORNING_LAG_RST,
    eveningLead: EVENING_LEAD_RST,
    sunPersist: SUN_PERSIST_RST,
    shadeLimit: SHADE_LIMIT_RST
  };

  // ****************************************************************
  // Shading conditions
  // ****************************************************************
  logic sunHeld;
  logic eligible;
  logic inSector;
  logic inWindow;
  logic shadeCond;
  logic [TIME_W:0] windowStart;
  logic [TIME_W:0] windowEnd;
  logic [TIME_W:0] nowWide;
  logic leadFits;
  logic [LEVEL_W-1:0] cappedLevel;
  rbss_mode_t modeNext;

  always_comb begin
    sunHeld = sunSync && (secCount >= state_q.cfg.sunPersist);
    eligible = request.upRequest && request.downRequest && shadeEnable && sunHeld;
    // Angles share one unit with the limits, so 90/180/270 degrees map straight through
    inSector = (calendarBus.azimuth >= state_q.cfg.azStart)
      && (calendarBus.azimuth <= state_q.cfg.azEnd)
      && (calendarBus.elevation < state_q.cfg.elevLimit);
    nowWide = {1'b0, calendarBus.timeOfDay};
    windowStart = {1'b0, calendarBus.sunrise} + {2'b00, state_q.cfg.morningLag};
    // A lead longer than the time to sunset closes the window instead of wrapping
    leadFits = {1'b0, state_q.cfg.eveningLead} <= calendarBus.sunset;
    windowEnd = {1'b0, calendarBus.sunset} - {2'b00, state_q.cfg.eveningLead};
    inWindow = leadFits && (nowWide > windowStart) && (nowWide < windowEnd);
    shadeCond = eligible && inSector && inWindow;
    if (request.requestedLevel < state_q.cfg.shadeLimit) begin
      cappedLevel = request.requestedLevel;
    end else begin
      cappedLevel = state_q.cfg.shadeLimit;
    end
    if (alertSync) begin
      modeNext = RBSS_ALERT;
    end else if (shadeCond) begin
      modeNext = RBSS_SHADE;
    end else begin
      modeNext = RBSS_PASS;
    end
  end

  // ****************************************************************
  // Next state: command, configuration writes, read data
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    state_d.mode = modeNext;
    case (modeNext)
      RBSS_ALERT: begin
        state_d.cmd.motorRaise = 1'b1;
        state_d.cmd.motorLower = 1'b0;
        state_d.cmd.status = STATUS_ALERT;
        state_d.cmd.targetLevel = request.requestedLevel;
      end
      RBSS_SHADE: begin
        state_d.cmd.motorRaise = request.upRequest;
        state_d.cmd.motorLower = request.downRequest;
        state_d.cmd.status = STATUS_SHADE;
        state_d.cmd.targetLevel = cappedLevel;
      end
      default: begin
        state_d.cmd.motorRaise = request.upRequest;
        state_d.cmd.motorLower = request.downRequest;
        state_d.cmd.status = request.upstreamStatus;
        state_d.cmd.targetLevel = request.requestedLevel;
      end
    endcase

    if (regBus.wrStrobe) begin
      case (regBus.addr)
        REG_AZ_START: state_d.cfg.azStart = regBus.wrData;
        REG_AZ_END: state_d.cfg.azEnd = regBus.wrData;
        REG_ELEV_LIMIT: state_d.cfg.elevLimit = regBus.wrData;
        REG_MORNING_LAG: state_d.cfg.morningLag = regBus.wrData;
        REG_EVENING_LEAD: state_d.cfg.eveningLead = regBus.wrData;
        REG_SUN_PERSIST: state_d.cfg.sunPersist = regBus.wrData;
        REG_SHADE_LIMIT: state_d.cfg.shadeLimit = regBus.wrData[LEVEL_W-1:0];
        default: begin
        end
      endcase
    end

    // Read data stands for exactly the cycle after the strobe
    state_d.rdData = '0;
    if (regBus.rdStrobe) begin
      case (regBus.addr)
        REG_AZ_START: state_d.rdData = state_q.cfg.azStart;
        REG_AZ_END: state_d.rdData = state_q.cfg.azEnd;
        REG_ELEV_LIMIT: state_d.rdData = state_q.cfg.elevLimit;
        REG_MORNING_LAG: state_d.rdData = state_q.cfg.morningLag;
        REG_EVENING_LEAD: state_d.rdData = state_q.cfg.eveningLead;
        REG_SUN_PERSIST: state_d.rdData = state_q.cfg.sunPersist;
        REG_SHADE_LIMIT: state_d.rdData = {{(DATA_W-LEVEL_W){1'b0}}, state_q.cfg.shadeLimit};
        REG_STATE: begin
          state_d.rdData[STATE_MODE_LSB +: 2] = state_q.mode;
          state_d.rdData[STATE_SUN_HELD_BIT] = sunHeld;
          state_d.rdData[STATE_ELIGIBLE_BIT] = eligible;
          state_d.rdData[STATE_SECTOR_BIT] = inSector;
          state_d.rdData[STATE_WINDOW_BIT] = inWindow;
        end
        default: state_d.rdData = '0;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_q.mode <= RBSS_PASS;
      state_q.cfg <= CFG_RST;
      state_q.cmd <= '0;
      state_q.rdData <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign command = state_q.cmd;
  assign rdData = state_q.rdData;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_passthrough;
    @(posedge sys_clk) disable iff (!nrst)
    (!alertSync && !shadeCond) |=> (command.motorRaise == $past(request.upRequest))
      && (command.motorLower == $past(request.downRequest))
      && (command.targetLevel == $past(request.requestedLevel));
  endproperty
  a_passthrough: assert property (p_passthrough) else $error("pass-through broken");

  property p_eligible;
    @(posedge sys_clk) disable iff (!nrst)
    (command.status == STATUS_SHADE && state_q.mode == RBSS_SHADE)
      |-> $past(request.upRequest && request.downRequest && shadeEnable && sunSync)
      && ($past(secCount) >= $past(state_q.cfg.sunPersist));
  endproperty
  a_eligible: assert property (p_eligible) else $error("shading without eligibility");

  property p_sector;
    @(posedge sys_clk) disable iff (!nrst)
    (state_q.mode == RBSS_SHADE) |-> $past(calendarBus.azimuth >= state_q.cfg.azStart)
      && $past(calendarBus.azimuth <= state_q.cfg.azEnd)
      && $past(calendarBus.elevation < state_q.cfg.elevLimit);
  endproperty
  a_sector: assert property (p_sector) else $error("shading outside sun sector");

  property p_window;
    @(posedge sys_clk) disable iff (!nrst)
    (state_q.mode == RBSS_SHADE) |-> $past(inWindow);
  endproperty
  a_window: assert property (p_window) else $error("shading outside day window");

  property p_shade_status;
    @(posedge sys_clk) disable iff (!nrst)
    (!alertSync && shadeCond) |=> (command.status == STATUS_SHADE);
  endproperty
  a_shade_status: assert property (p_shade_status) else $error("no shade status");

  property p_cap;
    @(posedge sys_clk) disable iff (!nrst)
    (!alertSync && shadeCond) |=> (command.targetLevel <= $past(state_q.cfg.shadeLimit))
      && (command.targetLevel <= $past(request.requestedLevel));
  endproperty
  a_cap: assert property (p_cap) else $error("target level above cap");

  property p_alert;
    @(posedge sys_clk) disable iff (!nrst)
    alertSync |=> command.motorRaise && !command.motorLower && (command.status == STATUS_ALERT);
  endproperty
  a_alert: assert property (p_alert) else $error("alert not forcing open");

  property p_forward;
    @(posedge sys_clk) disable iff (!nrst)
    (!alertSync && !shadeCond) |=> (command.status == $past(request.upstreamStatus));
  endproperty
  a_forward: assert property (p_forward) else $error("upstream status not forwarded");

  property p_defaults;
    @(posedge sys_clk) disable iff (!nrst)
    $rose(nrst) |-> (state_q.cfg.azStart == AZ_START_RST) && (state_q.cfg.azEnd == AZ_END_RST)
      && (state_q.cfg.elevLimit == ELEV_LIMIT_RST);
  endproperty
  a_defaults: assert property (p_defaults) else $error("angle defaults wrong");

  property p_time_defaults;
    @(posedge sys_clk) disable iff (!nrst)
    $rose(nrst) |-> (state_q.cfg.morningLag == MORNING_LAG_RST)
      && (state_q.cfg.eveningLead == EVENING_LEAD_RST);
  endproperty
  a_time_defaults: assert property (p_time_defaults) else $error("bad lag defaults");

  property p_def_persist;
    @(posedge sys_clk) disable iff (!nrst)
    $rose(nrst) |-> (state_q.cfg.sunPersist == SUN_PERSIST_RST);
  endproperty
  a_def_persist: assert property (p_def_persist) else $error("persist default");

  property p_leave;
    @(posedge sys_clk) disable iff (!nrst)
    (state_q.mode == RBSS_SHADE) ##0 (!shadeCond && !alertSync) |=> (state_q.mode == RBSS_PASS);
  endproperty
  a_leave: assert property (p_leave) else $error("shading not left");

  property p_alert_leave;
    @(posedge sys_clk) disable iff (!nrst)
    (state_q.mode == RBSS_ALERT) ##0 (!alertSync && !shadeCond)
      |=> (state_q.mode == RBSS_PASS);
  endproperty
  a_alert_leave: assert property (p_alert_leave) else $error("alert not left");

  property p_gate;
    @(posedge sys_clk) disable iff (!nrst)
    (!request.upRequest || !request.downRequest || !shadeEnable || !sunSync)
      |=> (state_q.mode != RBSS_SHADE);
  endproperty
  a_gate: assert property (p_gate) else $error("shading while not eligible");

  property p_sector_off;
    @(posedge sys_clk) disable iff (!nrst)
    !inSector |=> (state_q.mode != RBSS_SHADE);
  endproperty
  a_sector_off: assert property (p_sector_off) else $error("sector ignored");

  property p_window_off;
    @(posedge sys_clk) disable iff (!nrst)
    !inWindow |=> (state_q.mode != RBSS_SHADE);
  endproperty
  a_window_off: assert property (p_window_off) else $error("window ignored");

  property p_alert_mode;
    @(posedge sys_clk) disable iff (!nrst)
    alertSync |=> (state_q.mode == RBSS_ALERT);
  endproperty
  a_alert_mode: assert property (p_alert_mode) else $error("alert mode not entered");

  // ****************************************************************
  // Configuration writes
  // ****************************************************************
  property p_cfg_angle;
    @(posedge sys_clk) disable iff (!nrst)
    (regBus.wrStrobe && regBus.addr == REG_AZ_START)
      |=> (state_q.cfg.azStart == $past(regBus.wrData));
  endproperty
  a_cfg_angle: assert property (p_cfg_angle) else $error("az start not written");

  property p_cfg_time;
    @(posedge sys_clk) disable iff (!nrst)
    (regBus.wrStrobe && regBus.addr == REG_MORNING_LAG)
      |=> (state_q.cfg.morningLag == $past(regBus.wrData));
  endproperty
  a_cfg_time: assert property (p_cfg_time) else $error("lag not written");

  property p_cfg_persist;
    @(posedge sys_clk) disable iff (!nrst)
    (regBus.wrStrobe && regBus.addr == REG_SUN_PERSIST)
      |=> (state_q.cfg.sunPersist == $past(regBus.wrData));
  endproperty
  a_cfg_persist: assert property (p_cfg_persist) else $error("persist not written");

endmodule : rbss_top
`default_nettype wire

// ---- testbench/rbss_upstream_model.sv ----
// Preceding blind stage and calendar source feeding the sun-shading stage.
// Assumes the bench sets the wanted values by non-blocking assignment at a rising edge.
`timescale 1ns/1ns
`default_nettype none
module rbss_upstream_model
  import rbss_pkg::*;
(
  input wire logic sys_clk,
  input wire logic nrst,
  input wire rbss_request_t reqWant,
  input wire rbss_calendar_t calWant,
  output var rbss_request_t request,
  output var rbss_calendar_t calendarBus
);
  // ****************************************************************
  // Registered hand-over
  // ****************************************************************
  // Whole words move on one edge, so the stage never sees a half-updated value
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      request <= '0;
      calendarBus <= '0;
    end else begin
      request <= reqWant;
      // Azimuth in tenths of a degree: 900 east, 1800 south, 2700 west
      calendarBus <= calWant;
    end
  end
endmodule : rbss_upstream_model
`default_nettype wire

// ---- testbench/roller_blind_sun_shading_test.sv ----
// Self-checking bench of the sun-shading stage with an upstream stage model.
// Assumes rbss_top and the model on one 100 MHz clock; seconds shortened to 4 cycles.
`timescale 1ns/1ns
`default_nettype none
module roller_blind_sun_shading_test;
  import rbss_pkg::*;
  localparam int TICKS = 4;
  localparam logic [LEVEL_W-1:0] CAP = 8'h40;
  logic sys_clk = 1'b0;
  logic nrst = 1'b0;
  rbss_request_t reqW = '0;
  rbss_calendar_t calW = '0;
  rbss_request_t request;
  rbss_calendar_t calendarBus;
  logic shadeEnable = 1'b0;
  logic sunSensor = 1'b0;
  logic alertIn = 1'b0;
  rbss_regbus_t regBus = '0;
  logic [DATA_W-1:0] rdData;
  rbss_command_t command;
  rbss_request_t nReq = '0;
  rbss_calendar_t nCal = '0;
  logic nEn = 1'b0;
  logic nSun = 1'b0;
  logic nAlert = 1'b0;
  int miscompares = 0;
  int nChecks = 0;
  logic [31:0] seed = 32'h0001368f;

  always #5 sys_clk = ~sys_clk;

  rbss_upstream_model u_rbss_upstream_model (.sys_clk(sys_clk), .nrst(nrst), .reqWant(reqW),
    .calWant(calW), .request(request), .calendarBus(calendarBus));
  rbss_top #(.TICK_CYCLES(TICKS)) u_rbss_top (.sys_clk(sys_clk), .nrst(nrst),
    .request(request), .shadeEnable(shadeEnable), .sunSensor(sunSensor), .alertIn(alertIn),
    .calendarBus(calendarBus), .regBus(regBus), .rdData(rdData), .command(command));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xorshift();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xorshift

  function automatic rbss_command_t expCmd(input rbss_request_t r, input logic alert,
      input logic shade);
    rbss_command_t c;
    c = '{r.upRequest, r.downRequest, r.upstreamStatus, r.requestedLevel};
    if (alert) begin
      c.motorRaise = 1'b1;
      c.motorLower = 1'b0;
      c.status = STATUS_ALERT;
    end else if (shade) begin
      c.status = STATUS_SHADE;
      if (CAP < r.requestedLevel) begin
        c.targetLevel = CAP;
      end
    end
    return c;
  endfunction : expCmd

  task automatic results();
    $display("checks %0d mismatches %0d", nChecks, miscompares);
    if (miscompares == 0 && nChecks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  task automatic chkWord(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    nChecks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t word got %h want %h", $time, got, exp);
    end
  endtask : chkWord

  task automatic chkCmd(input rbss_command_t exp);
    nChecks++;
    if (command !== exp) begin
      miscompares++;
      $display("BAD t=%0t command got %h want %h", $time, command, exp);
    end
  endtask : chkCmd

  task automatic regWrite(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    regBus <= '{addr: a, wrData: d, wrStrobe: 1'b1, rdStrobe: 1'b0};
    @(posedge sys_clk);
    regBus.wrStrobe <= 1'b0;
  endtask : regWrite

  task automatic regRead(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    regBus <= '{addr: a, wrData: 16'h0000, wrStrobe: 1'b0, rdStrobe: 1'b1};
    @(posedge sys_clk);
    regBus.rdStrobe <= 1'b0;
    @(posedge sys_clk);
    d = rdData;
  endtask : regRead

  // Model adds one cycle, the stage one more; pins need extra for their synchroniser
  task automatic go(input int extra);
    @(posedge sys_clk);
    reqW <= nReq;
    calW <= nCal;
    shadeEnable <= nEn;
    sunSensor <= nSun;
    alertIn <= nAlert;
    repeat (2 + extra) @(posedge sys_clk);
    #1;
  endtask : go

  task automatic waitShade(output int n);
    n = 0;
    while (command.status !== STATUS_SHADE && n < 60) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 60) begin
      miscompares++;
      $display("BAD t=%0t shading never started", $time);
      results();
    end
  endtask : waitShade

  task automatic tryCal(input logic [15:0] az, input logic [15:0] el, input logic [16:0] tod,
      input logic shade);
    nCal.azimuth = az;
    nCal.elevation = el;
    nCal.timeOfDay = tod;
    go(0);
    chkCmd(expCmd(nReq, 1'b0, shade));
  endtask : tryCal

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] dflt [7];
    logic [31:0] t;
    int n;
    dflt = '{16'h03e8, 16'h0a28, 16'h0384, 16'h0e10, 16'h0e10, 16'h003c, 16'h00ff};
    repeat (20) @(posedge sys_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      regRead(4'(i), d);
      chkWord(d, dflt[i]);
    end
    regRead(4'h9, d);
    chkWord(d, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      t = xorshift();
      regWrite(4'(i), t[15:0]);
      regRead(4'(i), d);
      chkWord(d, t[15:0]);
      regWrite(4'(i), dflt[i]);
    end
    // Upper byte of the shade limit is not kept
    regWrite(REG_SHADE_LIMIT, 16'hab40);
    regWrite(REG_SUN_PERSIST, 16'h0002);
    regRead(REG_SHADE_LIMIT, d);
    chkWord(d, 16'h0040);
    $display("test registers done");
    nCal = '{16'h0708, 16'h012c, 17'h0a8c0, 17'h05460, 17'h0fd20};
    for (int i = 0; i < 20; i++) begin
      t = xorshift();
      nReq = t[17:0];
      nSun = t[20];
      go(0);
      chkCmd(expCmd(nReq, 1'b0, 1'b0));
    end
    // Sun low first, so the persistence count starts from zero
    nSun = 1'b0;
    go(2);
    chkCmd(expCmd(nReq, 1'b0, 1'b0));
    $display("test pass-through done");
    nReq = '{1'b1, 1'b1, 8'h12, 8'hc0};
    nEn = 1'b1;
    nSun = 1'b1;
    go(0);
    chkCmd(expCmd(nReq, 1'b0, 1'b0));
    waitShade(n);
    // Persistence is two seconds of sun by now
    chkWord({15'h0000, n >= 2 * TICKS}, 16'h0001);
    chkCmd(expCmd(nReq, 1'b0, 1'b1));
    regRead(REG_STATE, d);
    chkWord(d, 16'h003d);
    for (int i = 0; i < 12; i++) begin
      t = xorshift();
      nReq.requestedLevel = t[7:0];
      nReq.upstreamStatus = t[15:8];
      go(0);
      chkCmd(expCmd(nReq, 1'b0, 1'b1));
    end
    nReq.requestedLevel = 8'hc0;
    tryCal(16'h03e8, 16'h012c, 17'h0a8c0, 1'b1);
    tryCal(16'h03e7, 16'h012c, 17'h0a8c0, 1'b0);
    tryCal(16'h0a28, 16'h012c, 17'h0a8c0, 1'b1);
    tryCal(16'h0a29, 16'h012c, 17'h0a8c0, 1'b0);
    tryCal(16'h0708, 16'h0384, 17'h0a8c0, 1'b0);
    tryCal(16'h0708, 16'h0383, 17'h0a8c0, 1'b1);
    tryCal(16'h0708, 16'h012c, 17'h06270, 1'b0);
    tryCal(16'h0708, 16'h012c, 17'h06271, 1'b1);
    tryCal(16'h0708, 16'h012c, 17'h0ef10, 1'b0);
    tryCal(16'h0708, 16'h012c, 17'h0ef0f, 1'b1);
    nEn = 1'b0;
    go(0);
    chkCmd(expCmd(nReq, 1'b0, 1'b0));
    nEn = 1'b1;
    go(0);
    chkCmd(expCmd(nReq, 1'b0, 1'b1));
    $display("test shading done");
    nSun = 1'b0;
    go(2);
    chkCmd(expCmd(nReq, 1'b0, 1'b0));
    nSun = 1'b1;
    go(2);
    chkCmd(expCmd(nReq, 1'b0, 1'b0));
    waitShade(n);
    chkCmd(expCmd(nReq, 1'b0, 1'b1));
    $display("test persistence done");
    nAlert = 1'b1;
    go(2);
    chkCmd(expCmd(nReq, 1'b1, 1'b0));
    for (int i = 0; i < 6; i++) begin
      t = xorshift();
      nReq = t[17:0];
      go(0);
      chkCmd(expCmd(nReq, 1'b1, 1'b0));
    end
    nReq.upRequest = 1'b0;
    nAlert = 1'b0;
    go(2);
    chkCmd(expCmd(nReq, 1'b0, 1'b0));
    $display("test alert done");
    results();
  end
endmodule : roller_blind_sun_shading_test
`default_nettype wire
